// ===== blp_pkg.sv
/*
 package for the byte latch io port: widths, variant codes, reset values and carriers.
 assumes all users import blp_pkg::* and run on one clock.
*/
// Operation
// - the port holds one eight-bit value in a register, all bits loaded together, shown on buffered outputs.
// - an input variant follows the data inputs while its strobe is active and keeps the last value when the strobe ends.
// - the clear input empties the register of every variant only while the strobe is inactive.
// - the first input variant is selected only with its low-active select low and its high-active select high.
// - the second input variant is selected only with both high-active selects high.
// - both input variants float their outputs when deselected and drive the latched value only when selected.
// - the two input variants latch, clear and drive identically, differing only in select polarity.
// - the output variant loads its data inputs only while all of its selects are active.
// - the output variant has two high-active selects and one low-active select, all needed together.
// - the output variant drives its outputs at all times, whatever its selects and strobe do; the code floats them from reset until the first edge with ce high.
package blp_pkg;

   localparam int unsigned BLP_DATA_W = 8;

   // variant codes
   localparam logic [1:0] BLP_VAR_IN_MIXED = 2'h0;
   localparam logic [1:0] BLP_VAR_IN_HIGH  = 2'h1;
   localparam logic [1:0] BLP_VAR_OUT      = 2'h2;

   localparam logic [BLP_DATA_W-1:0] BLP_REG_RESET = 8'h00;
   localparam logic                  BLP_OE_RESET  = 1'b0;

   // select pins as the partner presents them
   typedef struct packed {
      logic sel_a_n;   // low-active select (ignored by high-only variant)
      logic sel_b;     // high-active select
      logic sel_c;     // high-active select (second input variant and output variant)
   } blp_sel_t;

   // pin-side output group
   typedef struct packed {
      logic [BLP_DATA_W-1:0] data;
      logic [BLP_DATA_W-1:0] oe;
   } blp_pins_t;

endpackage : blp_pkg

// ===== blp_select.sv
/*
 select decoder: turns the raw select pins into one selected flag per variant.
 assumes selects are synchronous to clk; selected is registered, selected_now is the unregistered decode.
*/
`timescale 1ns/10ps
module blp_select
   import blp_pkg::*;
#(
   parameter logic [1:0] VARIANT = BLP_VAR_IN_MIXED
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic ce,
   // selects
   input  wire blp_sel_t sel,
   // decoded
   output logic     selected,
   output logic     selected_now
);

   typedef struct packed {
      logic selected;
   } blp_sel_state_t;

   blp_sel_state_t st;
   blp_sel_state_t next_st;
   logic           dec;

   always_comb begin
      case (VARIANT)
         BLP_VAR_IN_MIXED: dec = !sel.sel_a_n && sel.sel_b;
         BLP_VAR_IN_HIGH:  dec = sel.sel_b && sel.sel_c;
         BLP_VAR_OUT:      dec = !sel.sel_a_n && sel.sel_b && sel.sel_c;
         default:          dec = 1'b0;
      endcase
      next_st = st;
      if (ce) begin
         next_st.selected = dec;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign selected     = st.selected;
   assign selected_now = dec;

   AST_SEL_TRACK: assert property (@(posedge clk) disable iff (sys_rst)
      ce |=> selected == $past(dec))
      else $error("select flag did not follow decode");

endmodule // blp_select

// ===== blp_latch.sv
/*
 eight-bit data latch register with load and clear, all bits in one generate loop.
 assumes load and clear are never both high; load wins if they are.
*/
`timescale 1ns/10ps
module blp_latch
   import blp_pkg::*;
#(
   parameter int unsigned WIDTH = BLP_DATA_W
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic             ce,
   // control
   input  wire logic             load,
   input  wire logic             clear,
   input  wire logic [WIDTH-1:0] din,
   // content
   output logic      [WIDTH-1:0] q
);

   typedef struct packed {
      logic [WIDTH-1:0] q;
   } blp_lat_state_t;

   blp_lat_state_t st;
   blp_lat_state_t next_st;

   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_comb begin
         next_st.q[i] = st.q[i];
         if (ce && load) begin
            next_st.q[i] = din[i];
         end else if (ce && clear) begin
            next_st.q[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign q = st.q;

   AST_LAT_LOAD: assert property (@(posedge clk) disable iff (sys_rst)
      ce && load |=> q == $past(din))
      else $error("latch missed a load");

   AST_LAT_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
      ce && clear && !load |=> q == '0)
      else $error("latch missed a clear");

endmodule // blp_latch

// ===== blp_port.sv
/*
 byte latch io port top: one core for the two input variants and the output variant.
 assumes strobe, clear, selects and data are synchronous to clk; a clear raised together
 with the strobe is ignored. pins are split into out and enable; the
 wire level is resolved outside.
*/
`timescale 1ns/10ps
module blp_port
   import blp_pkg::*;
#(
   parameter logic [1:0]  VARIANT = BLP_VAR_IN_MIXED,
   parameter int unsigned WIDTH   = BLP_DATA_W
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic             ce,
   // strobe and clear
   input  wire logic             strobe,
   input  wire logic             register_reset_in,
   // selects
   input  wire blp_sel_t         sel,
   // data
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout,
   output logic      [WIDTH-1:0] dout_oe
);

   localparam logic IS_OUT = (VARIANT == BLP_VAR_OUT);

   typedef enum {ST_IDLE, ST_FOLLOW} blp_mode_t;

   typedef struct packed {
      blp_mode_t        mode;
      logic [WIDTH-1:0] dout;
      logic [WIDTH-1:0] oe;
   } blp_top_state_t;

   blp_top_state_t st;
   blp_top_state_t next_st;

   logic             selected;
   logic             selected_now;
   logic             load;
   logic             clear;
   logic [WIDTH-1:0] q;

   blp_select #(
      .VARIANT (VARIANT)
   ) u_sel (
      .clk          (clk),
      .sys_rst      (sys_rst),
      .ce           (ce),
      .sel          (sel),
      .selected     (selected),
      .selected_now (selected_now)
   );

   // input variants follow data for the whole strobe; the output variant also needs selects
   always_comb begin
      if (IS_OUT) begin
         load = strobe && selected_now;
      end else begin
         load = strobe;
      end
      clear = register_reset_in && !strobe;
   end

   blp_latch #(
      .WIDTH (WIDTH)
   ) u_lat (
      .clk     (clk),
      .sys_rst (sys_rst),
      .ce      (ce),
      .load    (load),
      .clear   (clear),
      .din     (din),
      .q       (q)
   );

   always_comb begin
      next_st = st;
      if (ce) begin
         case (st.mode)
            ST_IDLE:   next_st.mode = load ? ST_FOLLOW : ST_IDLE;
            ST_FOLLOW: next_st.mode = load ? ST_FOLLOW : ST_IDLE;
            default:   next_st.mode = ST_IDLE;
         endcase
         // the register itself lags one cycle; outputs mirror it one more cycle later
         next_st.dout = q;
         if (IS_OUT) begin
            next_st.oe = '1;
         end else begin
            next_st.oe = {WIDTH{selected}};
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st.mode <= ST_IDLE;
         st.dout <= '0;
         st.oe   <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign dout    = st.dout;
   assign dout_oe = st.oe;

   AST_FOLLOW: assert property (@(posedge clk) disable iff (sys_rst)
      ce && load ##1 ce |=> dout == $past(din, 2))
      else $error("output did not follow strobed data");

   AST_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
      ce && !load && !clear ##1 ce && !load && !clear |=> $stable(dout))
      else $error("output changed without load or clear");

   AST_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
      ce && clear && !load ##1 ce |=> dout == '0)
      else $error("clear did not empty the register");

   AST_CLEAR_BLOCKED: assert property (@(posedge clk) disable iff (sys_rst)
      ce && strobe && !IS_OUT |=> q == $past(din))
      else $error("clear acted during strobe");

   AST_OE_IN: assert property (@(posedge clk) disable iff (sys_rst)
      !IS_OUT && ce ##1 ce |=> dout_oe == {WIDTH{$past(selected_now, 2)}})
      else $error("input variant enable not tied to select");

   // the enable flop is still in reset at the releasing edge, so skip the first edge after it
   AST_OE_OUT: assert property (@(posedge clk) disable iff (sys_rst)
      IS_OUT && ce && !$past(sys_rst) |=> dout_oe == '1)
      else $error("output variant floated its pins");

   AST_OUT_NOSEL: assert property (@(posedge clk) disable iff (sys_rst)
      IS_OUT && ce && !selected_now |=> q == $past(q) || $past(clear))
      else $error("output variant loaded while deselected");

   AST_SEL_MIX: assert property (@(posedge clk) disable iff (sys_rst)
      VARIANT == BLP_VAR_IN_MIXED && ce && sel.sel_a_n |=> !selected)
      else $error("mixed variant selected with low select high");

   AST_SEL_HIGH: assert property (@(posedge clk) disable iff (sys_rst)
      VARIANT == BLP_VAR_IN_HIGH && ce && sel.sel_b && sel.sel_c |=> selected)
      else $error("high variant not selected");

   AST_SEL_OUT: assert property (@(posedge clk) disable iff (sys_rst)
      IS_OUT && ce && !(sel.sel_b && sel.sel_c && !sel.sel_a_n) |=> !selected)
      else $error("output variant selected with a select inactive");

endmodule // blp_port

// ===== blp_bus_model.sv
/*
 processor-side bus model for the byte latch io port: resolves the port's split
 outputs into the byte that the processor data bus carries.
 assumes one clock; undriven bits have neither pull-up nor pull-down.
*/
`timescale 1ns/10ps
module blp_bus_model
   import blp_pkg::*;
(
   // port side
   input  wire logic                  clk,
   input  wire logic [BLP_DATA_W-1:0] dout,
   input  wire logic [BLP_DATA_W-1:0] dout_oe,
   // bus as the processor sees it
   output logic      [BLP_DATA_W-1:0] bus
);
   logic [BLP_DATA_W-1:0] last = 8'h00;

   always_ff @(posedge clk) begin
      for (int i = 0; i < BLP_DATA_W; i++) begin
         if (dout_oe[i]) last[i] <= dout[i];
      end
   end

   // a floating bit shows the inverse of its last driven level, so stale data cannot match
   always_comb begin
      for (int i = 0; i < BLP_DATA_W; i++) begin
         bus[i] = dout_oe[i] ? dout[i] : ~last[i];
      end
   end
endmodule // blp_bus_model

// ===== byte_latch_io_port_tb.sv
/*
 self-checking bench for the byte latch io port: all three variants share one stimulus.
 assumes the bus model resolves the mixed-select input port onto the processor bus.
*/
`timescale 1ns/10ps
module byte_latch_io_port_tb;
   import blp_pkg::*;
   logic       clk;
   logic       sys_rst;
   logic       ce;
   logic       strobe;
   logic       clear;
   blp_sel_t   sel;
   logic [7:0] din;
   logic [7:0] dm, om, dh, oh, dq, oq, bus;
   int         errors;
   int         n_checks;

   blp_port #(.VARIANT(BLP_VAR_IN_MIXED)) u_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce),
      .strobe(strobe), .register_reset_in(clear), .sel(sel), .din(din), .dout(dm), .dout_oe(om));
   blp_port #(.VARIANT(BLP_VAR_IN_HIGH)) u_dut_high (.clk(clk), .sys_rst(sys_rst), .ce(ce),
      .strobe(strobe), .register_reset_in(clear), .sel(sel), .din(din), .dout(dh), .dout_oe(oh));
   blp_port #(.VARIANT(BLP_VAR_OUT)) u_dut_out (.clk(clk), .sys_rst(sys_rst), .ce(ce),
      .strobe(strobe), .register_reset_in(clear), .sel(sel), .din(din), .dout(dq), .dout_oe(oq));
   blp_bus_model u_bus (.clk(clk), .dout(dm), .dout_oe(om), .bus(bus));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // two edges of latency: one to take the request, one to show it
   task automatic drive(input logic s, input logic c, input blp_sel_t sl, input logic [7:0] d);
      @(posedge clk);
      strobe <= s;
      clear  <= c;
      sel    <= sl;
      din    <= d;
      repeat (2) @(posedge clk);
      #1;
   endtask

   task automatic t_latch;
      drive(1'b1, 1'b0, 3'b011, 8'hA5);
      chk(dm, 8'hA5);
      chk(dq, 8'hA5);
      drive(1'b1, 1'b0, 3'b011, 8'h5A);
      chk(dh, 8'h5A);
      drive(1'b0, 1'b0, 3'b011, 8'h3C);
      chk(dm, 8'h5A);
      chk(dh, 8'h5A);
      chk(dq, 8'h5A);
   endtask

   task automatic t_clear;
      drive(1'b1, 1'b1, 3'b011, 8'h77);
      chk(dm, 8'h77);
      chk(dq, 8'h77);
      drive(1'b0, 1'b1, 3'b011, 8'h11);
      chk(dm, 8'h00);
      chk(dh, 8'h00);
      chk(dq, 8'h00);
      drive(1'b0, 1'b0, 3'b011, 8'h11);
   endtask

   task automatic t_select;
      blp_sel_t   s;
      logic [7:0] exp_o;
      logic       m;
      exp_o = 8'h00;
      for (int i = 0; i < 8; i++) begin
         s = blp_sel_t'(i[2:0]);
         m = !s.sel_a_n & s.sel_b;
         drive(1'b1, 1'b0, s, 8'h10 + i[7:0]);
         drive(1'b0, 1'b0, s, 8'h00);
         if (!s.sel_a_n & s.sel_b & s.sel_c) exp_o = 8'h10 + i[7:0];
         chk(dm, 8'h10 + i[7:0]);
         chk(dh, 8'h10 + i[7:0]);
         chk(dq, exp_o);
         chk(om, {8{m}});
         chk(oh, {8{s.sel_b & s.sel_c}});
         chk(oq, 8'hFF);
         chk({7'h00, bus === dm}, {7'h00, m});
      end
   endtask

   // ce low must freeze every port flop even with a full strobe and live selects
   task automatic t_freeze;
      @(posedge clk);
      ce <= 1'b0;
      drive(1'b1, 1'b0, 3'b011, 8'h66);
      chk(dm, 8'h17);
      chk(dq, 8'h13);
      chk(om, 8'h00);
      @(posedge clk);
      ce <= 1'b1;
      drive(1'b0, 1'b0, 3'b011, 8'h66);
      chk(dm, 8'h66);
      chk(dq, 8'h66);
      chk(om, 8'hFF);
   endtask

   task automatic complete_run;
      $display("checks=%0d errors=%0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      errors   = 0;
      n_checks = 0;
      sys_rst  = 1'b1;
      ce       = 1'b1;
      strobe   = 1'b0;
      clear    = 1'b0;
      sel      = 3'b100;
      din      = 8'h00;
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk(dm, 8'h00);
      chk(om, 8'h00);
      chk(oq, 8'hFF);
      t_latch();
      t_clear();
      t_select();
      t_freeze();
      complete_run();
   end

   // the whole sequence needs well under 100 cycles per step
   initial begin
      #100000;
      errors++;
      complete_run();
   end
endmodule // byte_latch_io_port_tb
